// *** rtl/char_lcd_pkg.sv ***
// Constants, types and the register map of the character LCD I2C host port
package char_lcd_pkg;

   // Clock and serial bit timing
   localparam int CLK_PERIOD_NS  = 40;
   localparam int SCL_PERIOD_NS  = 10000;
   localparam int QTR_CYCLES     = (SCL_PERIOD_NS + 4 * CLK_PERIOD_NS - 1) / (4 * CLK_PERIOD_NS);
   localparam int QTR_W          = 8;
   localparam logic [QTR_W-1:0] QTR_LAST = QTR_W'(QTR_CYCLES - 1);

   // Fixed wait after each instruction, since the busy state cannot be read back
   localparam int CMD_WAIT_US     = 2000;
   localparam int CMD_WAIT_CYCLES = (CMD_WAIT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // Register offsets (byte addresses)
   localparam logic [7:0] REG_CTRL   = 8'h00;
   localparam logic [7:0] REG_WORD   = 8'h04;
   localparam logic [7:0] REG_STATUS = 8'h08;
   localparam logic [7:0] REG_SLAVE  = 8'h0C;

   // Field positions
   localparam int CTRL_GO_BIT     = 0;
   localparam int CTRL_SUPPLY_BIT = 1;
   localparam int CTRL_SEND_BIT   = 2;
   localparam int CTRL_LCDRST_BIT = 3;
   localparam int WORD_RS_BIT     = 8;
   localparam int STAT_BUSY_BIT   = 0;
   localparam int STAT_NACK_BIT   = 1;
   localparam int STAT_DONE_BIT   = 2;

   // Values after reset
   localparam logic       SUPPLY_RST    = 1'b0;
   localparam logic       LCDRST_RST    = 1'b0;
   localparam logic [1:0] SLAVE_SEL_RST = 2'h0;
   localparam logic [8:0] WORD_RST      = 9'h000;

   // Bus framing
   localparam logic [6:0] SLAVE_BASE     = 7'h3C;
   localparam logic       RW_WRITE       = 1'b0;
   localparam logic [7:0] CTRL_BYTE_CMD  = 8'h00;
   localparam logic [7:0] CTRL_BYTE_DATA = 8'h40;
   localparam logic [1:0] BYTE_LAST      = 2'h2;

   // Power-up command sequence
   localparam logic [7:0] CMD_FUNC_A      = 8'h38;
   localparam logic [7:0] CMD_FUNC_B      = 8'h39;
   localparam logic [7:0] CMD_OSC         = 8'h14;
   localparam logic [7:0] CMD_CONTRAST_3V = 8'h74;
   localparam logic [7:0] CMD_POWER_3V    = 8'h54;
   localparam logic [7:0] CMD_FOLLOW_3V   = 8'h6F;
   localparam logic [7:0] CMD_CONTRAST_5V = 8'h79;
   localparam logic [7:0] CMD_POWER_5V    = 8'h50;
   localparam logic [7:0] CMD_FOLLOW_5V   = 8'h6C;
   localparam logic [7:0] CMD_DISPLAY_ON  = 8'h0C;
   localparam logic [7:0] CMD_CLEAR       = 8'h01;
   localparam logic [2:0] INIT_LAST_STEP  = 3'h7;

   typedef enum logic [2:0] {
      ST_IDLE  = 3'b000,
      ST_START = 3'b001,
      ST_BIT   = 3'b010,
      ST_ACK   = 3'b011,
      ST_STOP  = 3'b100,
      ST_GAP   = 3'b101
   } state_t;

   // One command word: register select plus its byte
   typedef struct packed {
      logic       register_select;
      logic [7:0] data;
   } lcd_word_t;

endpackage

// *** rtl/char_lcd_i2c_host_port.sv ***
// I2C master that initialises and writes a character LCD controller
`timescale 1ns/1ps
`default_nettype none

module char_lcd_i2c_host_port #(
   parameter int CMD_WAIT = char_lcd_pkg::CMD_WAIT_CYCLES,
   parameter int QTR      = char_lcd_pkg::QTR_CYCLES,
   parameter int WAIT_W   = $clog2(CMD_WAIT + 1)
) (
   input  wire logic        clk,
   input  wire logic        nrst,
   input  wire logic [7:0]  addr,
   input  wire logic [31:0] wdata,
   input  wire logic        wr,
   input  wire logic        rd,
   output logic      [31:0] rdata,
   input  wire logic        sda_in,
   output logic             sda_out,
   output logic             sda_oe,
   output logic             scl_out,
   output logic             scl_oe,
   output logic             lcd_rst_n
);

   localparam logic [WAIT_W-1:0] WAIT_LAST = WAIT_W'(CMD_WAIT - 1);
   // Quarter length must fit the quarter counter; the default gives a 10 us clock
   localparam int                QW        = char_lcd_pkg::QTR_W;
   localparam logic [QW-1:0]     QTR_END   = QW'(QTR - 1);

   char_lcd_pkg::state_t              state_r;
   logic [1:0]                        ph_r;
   logic [2:0]                        bit_r;
   logic [1:0]                        byte_r;
   logic [2:0]                        step_r;
   logic                              init_r;
   logic                              ack_ok_r;
   logic [char_lcd_pkg::QTR_W-1:0]    qcnt_r;
   logic [WAIT_W-1:0]                 wait_cnt_r;
   logic                              supply_r;
   logic                              hold_rst_r;
   logic [1:0]                        slave_sel_r;
   char_lcd_pkg::lcd_word_t           word_r;
   logic                              nack_r;
   logic                              done_r;
   logic                              sda_s1_r;
   logic                              sda_s2_r;
   logic                              scl_low_nxt;
   logic                              sda_low_nxt;
   logic                              tick;
   logic                              go;
   logic                              send;
   logic                              ack_sample;
   logic                              init_end;
   char_lcd_pkg::lcd_word_t           cur_word;
   logic [7:0]                        cur_byte;
   logic [31:0]                       rd_mux;

   // Power-up command for a given step, chosen by supply
   function automatic logic [7:0] init_cmd(input logic [2:0] step, input logic five_volt);
      logic [7:0] c;
      c = char_lcd_pkg::CMD_CLEAR;
      case (step)
         3'h0:    c = char_lcd_pkg::CMD_FUNC_A;
         3'h1:    c = char_lcd_pkg::CMD_FUNC_B;
         3'h2:    c = char_lcd_pkg::CMD_OSC;
         3'h3:    c = five_volt ? char_lcd_pkg::CMD_CONTRAST_5V : char_lcd_pkg::CMD_CONTRAST_3V;
         3'h4:    c = five_volt ? char_lcd_pkg::CMD_POWER_5V : char_lcd_pkg::CMD_POWER_3V;
         3'h5:    c = five_volt ? char_lcd_pkg::CMD_FOLLOW_5V : char_lcd_pkg::CMD_FOLLOW_3V;
         3'h6:    c = char_lcd_pkg::CMD_DISPLAY_ON;
         default: c = char_lcd_pkg::CMD_CLEAR;
      endcase
      return c;
   endfunction

   // Orders are taken only on an idle engine; others are dropped
   assign go   = wr && (addr == char_lcd_pkg::REG_CTRL) && wdata[char_lcd_pkg::CTRL_GO_BIT]
                 && (state_r == char_lcd_pkg::ST_IDLE);
   assign send = wr && (addr == char_lcd_pkg::REG_CTRL) && wdata[char_lcd_pkg::CTRL_SEND_BIT]
                 && (state_r == char_lcd_pkg::ST_IDLE) && !go;
   assign tick       = (qcnt_r == QTR_END);
   assign ack_sample = (state_r == char_lcd_pkg::ST_ACK) && (ph_r == 2'h2) && tick;
   assign init_end   = (state_r == char_lcd_pkg::ST_GAP) && (wait_cnt_r == WAIT_LAST) && init_r
                       && (!ack_ok_r || step_r == char_lcd_pkg::INIT_LAST_STEP);

   // Word in flight: power-up table while initialising, else the software word
   always_comb
   begin
      cur_word.register_select = init_r ? 1'b0 : word_r.register_select;
      cur_word.data            = init_r ? init_cmd(step_r, supply_r) : word_r.data;
   end

   // Byte order: address with write bit, control byte, then the data byte
   always_comb
   begin
      case (byte_r)
         2'h0:    cur_byte = {char_lcd_pkg::SLAVE_BASE[6:2], slave_sel_r,
                              char_lcd_pkg::RW_WRITE};
         2'h1:    cur_byte = cur_word.register_select ? char_lcd_pkg::CTRL_BYTE_DATA
                                                      : char_lcd_pkg::CTRL_BYTE_CMD;
         default: cur_byte = cur_word.data;
      endcase
   end

   // Line levels per state and quarter; high means pull the line low
   always_comb
   begin
      scl_low_nxt = 1'b0;
      sda_low_nxt = 1'b0;
      case (state_r)
         char_lcd_pkg::ST_START:
         begin
            scl_low_nxt = ph_r[1];
            sda_low_nxt = (ph_r != 2'h0);
         end
         char_lcd_pkg::ST_BIT:
         begin
            scl_low_nxt = (ph_r == 2'h0) || (ph_r == 2'h3);
            sda_low_nxt = !cur_byte[bit_r];
         end
         char_lcd_pkg::ST_ACK:
         begin
            scl_low_nxt = (ph_r == 2'h0) || (ph_r == 2'h3);
            sda_low_nxt = 1'b0;
         end
         char_lcd_pkg::ST_STOP:
         begin
            scl_low_nxt = (ph_r == 2'h0);
            sda_low_nxt = !ph_r[1];
         end
         default:
         begin
            scl_low_nxt = 1'b0;
            sda_low_nxt = 1'b0;
         end
      endcase
   end

   // Pin drivers; both pins are open drain so the driven level is always low
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         scl_oe    <= 1'b0;
         sda_oe    <= 1'b0;
         scl_out   <= 1'b0;
         sda_out   <= 1'b0;
         lcd_rst_n <= 1'b0;
      end
      else
      begin
         scl_oe    <= scl_low_nxt;
         sda_oe    <= sda_low_nxt;
         scl_out   <= 1'b0;
         sda_out   <= 1'b0;
         lcd_rst_n <= !hold_rst_r;
      end
   end

   // Data line synchroniser; only the second stage is read
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         sda_s1_r <= 1'b1;
         sda_s2_r <= 1'b1;
      end
      else
      begin
         sda_s1_r <= sda_in;
         sda_s2_r <= sda_s1_r;
      end
   end

   // Quarter-bit timer, free only while a frame is on the bus
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         qcnt_r <= '0;
      else if (state_r == char_lcd_pkg::ST_IDLE || state_r == char_lcd_pkg::ST_GAP || tick)
         qcnt_r <= '0;
      else
         qcnt_r <= qcnt_r + 1'b1;
   end

   // Settling time after each frame; no clock stretching so a fixed wait
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         wait_cnt_r <= '0;
      else if (state_r == char_lcd_pkg::ST_GAP)
         wait_cnt_r <= wait_cnt_r + 1'b1;
      else
         wait_cnt_r <= '0;
   end

   // Frame sequencer
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         state_r  <= char_lcd_pkg::ST_IDLE;
         ph_r     <= 2'h0;
         bit_r    <= 3'h7;
         byte_r   <= 2'h0;
         step_r   <= 3'h0;
         init_r   <= 1'b0;
         ack_ok_r <= 1'b1;
      end
      else
      begin
         case (state_r)
            char_lcd_pkg::ST_IDLE:
            begin
               ph_r     <= 2'h0;
               ack_ok_r <= 1'b1;
               if (go || send)
               begin
                  state_r <= char_lcd_pkg::ST_START;
                  init_r  <= go;
                  step_r  <= 3'h0;
               end
            end
            char_lcd_pkg::ST_START:
            begin
               if (tick)
               begin
                  ph_r <= ph_r + 1'b1;
                  if (ph_r == 2'h3)
                  begin
                     state_r <= char_lcd_pkg::ST_BIT;
                     byte_r  <= 2'h0;
                     bit_r   <= 3'h7;
                  end
               end
            end
            char_lcd_pkg::ST_BIT:
            begin
               if (tick)
               begin
                  ph_r <= ph_r + 1'b1;
                  if (ph_r == 2'h3)
                  begin
                     if (bit_r == 3'h0)
                        state_r <= char_lcd_pkg::ST_ACK;
                     else
                        bit_r <= bit_r - 1'b1;
                  end
               end
            end
            char_lcd_pkg::ST_ACK:
            begin
               if (ack_sample)
                  ack_ok_r <= !sda_s2_r;
               if (tick)
               begin
                  ph_r <= ph_r + 1'b1;
                  if (ph_r == 2'h3)
                  begin
                     // A missing acknowledge ends the frame at once
                     if (!ack_ok_r || byte_r == char_lcd_pkg::BYTE_LAST)
                        state_r <= char_lcd_pkg::ST_STOP;
                     else
                     begin
                        state_r <= char_lcd_pkg::ST_BIT;
                        byte_r  <= byte_r + 1'b1;
                        bit_r   <= 3'h7;
                     end
                  end
               end
            end
            char_lcd_pkg::ST_STOP:
            begin
               if (tick)
               begin
                  ph_r <= ph_r + 1'b1;
                  if (ph_r == 2'h3)
                     state_r <= char_lcd_pkg::ST_GAP;
               end
            end
            char_lcd_pkg::ST_GAP:
            begin
               ph_r <= 2'h0;
               if (wait_cnt_r == WAIT_LAST)
               begin
                  // Each power-up command goes in a frame of its own
                  if (init_r && ack_ok_r && step_r != char_lcd_pkg::INIT_LAST_STEP)
                  begin
                     step_r  <= step_r + 1'b1;
                     state_r <= char_lcd_pkg::ST_START;
                  end
                  else
                  begin
                     state_r <= char_lcd_pkg::ST_IDLE;
                     init_r  <= 1'b0;
                  end
               end
            end
            default:
               state_r <= char_lcd_pkg::ST_IDLE;
         endcase
      end
   end

   // Software settings
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         supply_r    <= char_lcd_pkg::SUPPLY_RST;
         hold_rst_r  <= char_lcd_pkg::LCDRST_RST;
         slave_sel_r <= char_lcd_pkg::SLAVE_SEL_RST;
         word_r      <= char_lcd_pkg::WORD_RST;
      end
      else if (wr)
      begin
         // Supply and word are frozen while a frame uses them
         if (addr == char_lcd_pkg::REG_CTRL)
         begin
            hold_rst_r <= wdata[char_lcd_pkg::CTRL_LCDRST_BIT];
            if (state_r == char_lcd_pkg::ST_IDLE)
               supply_r <= wdata[char_lcd_pkg::CTRL_SUPPLY_BIT];
         end
         if (addr == char_lcd_pkg::REG_WORD && state_r == char_lcd_pkg::ST_IDLE)
            word_r <= wdata[char_lcd_pkg::WORD_RS_BIT:0];
         if (addr == char_lcd_pkg::REG_SLAVE && state_r == char_lcd_pkg::ST_IDLE)
            slave_sel_r <= wdata[1:0];
      end
   end

   // Sticky flags; a new event beats a clear in the same cycle
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         nack_r <= 1'b0;
         done_r <= 1'b0;
      end
      else
      begin
         if (ack_sample && sda_s2_r)
            nack_r <= 1'b1;
         else if (wr && addr == char_lcd_pkg::REG_STATUS && wdata[char_lcd_pkg::STAT_NACK_BIT])
            nack_r <= 1'b0;
         if (init_end)
            done_r <= ack_ok_r;
         else if (go)
            done_r <= 1'b0;
      end
   end

   // Read mux; unmapped offsets read as zero
   always_comb
   begin
      rd_mux = 32'h0000_0000;
      case (addr)
         char_lcd_pkg::REG_CTRL:
         begin
            rd_mux[char_lcd_pkg::CTRL_SUPPLY_BIT] = supply_r;
            rd_mux[char_lcd_pkg::CTRL_LCDRST_BIT] = hold_rst_r;
         end
         char_lcd_pkg::REG_WORD:   rd_mux[8:0] = word_r;
         char_lcd_pkg::REG_STATUS:
         begin
            rd_mux[char_lcd_pkg::STAT_BUSY_BIT] = (state_r != char_lcd_pkg::ST_IDLE);
            rd_mux[char_lcd_pkg::STAT_NACK_BIT] = nack_r;
            rd_mux[char_lcd_pkg::STAT_DONE_BIT] = done_r;
            rd_mux[6:4]                         = step_r;
         end
         char_lcd_pkg::REG_SLAVE:  rd_mux[1:0] = slave_sel_r;
         default:                  rd_mux = 32'h0000_0000;
      endcase
   end

   // Read data stand only in the cycle after the strobe
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         rdata <= 32'h0000_0000;
      else
         rdata <= rd ? rd_mux : 32'h0000_0000;
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);

   // Line protocol, instruction wait and power-up table checks
   idle_release_a: assert property (($past(state_r) == char_lcd_pkg::ST_IDLE
      && state_r == char_lcd_pkg::ST_IDLE) |-> (!scl_oe && !sda_oe))
      else $error("bus not released while idle");
   sda_stable_a: assert property (($past(state_r) inside {char_lcd_pkg::ST_BIT, char_lcd_pkg::ST_ACK}
      && !scl_oe && !$past(scl_oe)) |-> $stable(sda_oe))
      else $error("data changed while clock high");
   start_cond_a: assert property (($rose(sda_oe) && !scl_oe)
      |-> $past(state_r) == char_lcd_pkg::ST_START)
      else $error("data fell with clock high outside start");
   stop_cond_a: assert property (($fell(sda_oe) && !scl_oe)
      |-> $past(state_r) == char_lcd_pkg::ST_STOP)
      else $error("data rose with clock high outside stop");
   ack_release_a: assert property ((state_r == char_lcd_pkg::ST_ACK && ph_r == 2'h2)
      |-> !sda_oe && !scl_oe)
      else $error("data not released on acknowledge clock");
   write_bit_a: assert property ((state_r == char_lcd_pkg::ST_BIT && byte_r == 2'h0
      && bit_r == 3'h0 && ph_r == 2'h2) |-> sda_oe)
      else $error("direction bit not zero");
   ctrl_last_a: assert property ((state_r == char_lcd_pkg::ST_BIT && byte_r == 2'h1
      && bit_r == 3'h7 && ph_r == 2'h2) |-> sda_oe)
      else $error("continuation flag not cleared");
   start_idle_a: assert property ($rose(state_r == char_lcd_pkg::ST_START)
      |-> $past(state_r) inside {char_lcd_pkg::ST_IDLE, char_lcd_pkg::ST_GAP})
      else $error("frame started on a busy bus");
   gap_length_a: assert property (($past(state_r) == char_lcd_pkg::ST_GAP
      && state_r != char_lcd_pkg::ST_GAP) |-> $past(wait_cnt_r) == WAIT_LAST)
      else $error("instruction wait cut short");
   init_first_a: assert property ((init_r && step_r == 3'h0 && state_r == char_lcd_pkg::ST_BIT
      && byte_r == 2'h2) |-> cur_byte == char_lcd_pkg::CMD_FUNC_A)
      else $error("power-up does not open with function set");
   contrast_a: assert property ((init_r && step_r == 3'h3 && byte_r == 2'h2)
      |-> cur_byte == (supply_r ? char_lcd_pkg::CMD_CONTRAST_5V
                                : char_lcd_pkg::CMD_CONTRAST_3V))
      else $error("contrast value does not match supply");

   init_done_c: cover property ($rose(done_r));
   nack_seen_c: cover property ($rose(nack_r));
   data_word_c: cover property (state_r == char_lcd_pkg::ST_STOP && !init_r
      && word_r.register_select);
   back_frame_c: cover property (state_r == char_lcd_pkg::ST_GAP ##1
      state_r == char_lcd_pkg::ST_START);

endmodule // char_lcd_i2c_host_port

`default_nettype wire

// *** tb/lcd_slave_model.sv ***
// Behavioural LCD controller seen as an I2C slave receiver
`timescale 1ns/1ps
`default_nettype none
module lcd_slave_model #(
   parameter logic [6:0] ADDR = 7'h3C
) (
   input  wire logic scl,
   input  wire logic sda,
   input  wire logic rst_n,
   output logic      sda_pull
);
   char_lcd_pkg::lcd_word_t words[$];
   logic [7:0] sh;
   int         bits = 0;
   int         idx = -1;
   logic       sel = 1'b0;
   logic       want_ctrl;
   logic       co;
   logic       rs;

   initial sda_pull = 1'b0;

   // A module held in reset lets go of the data line at once
   always @(negedge rst_n)
   begin
      sda_pull = 1'b0;
      idx = -1;
      bits = 0;
   end

   // Start opens a frame; ignored while the module is held in reset
   always @(negedge sda)
      if (scl && rst_n)
      begin
         idx = 0;
         bits = 0;
      end

   // Stop closes the frame
   always @(posedge sda)
      if (scl)
         idx = -1;

   // Data is taken while the clock is high
   always @(posedge scl)
      if (idx >= 0 && bits < 8)
      begin
         sh = {sh[6:0], sda};
         bits++;
      end

   // Ack from the eighth falling clock to the ninth; only a plain bus handshake
   always @(negedge scl)
      if (bits == 9)
      begin
         sda_pull = 1'b0;
         bits = 0;
      end
      else if (idx >= 0 && bits == 8)
      begin
         if (idx == 0)
         begin
            sel = (sh[7:1] == ADDR) && !sh[0];
            want_ctrl = 1'b1;
         end
         else if (sel && want_ctrl)
         begin
            co = sh[7];
            rs = sh[6];
            want_ctrl = 1'b0;
         end
         else if (sel)
         begin
            words.push_back({rs, sh});
            want_ctrl = co;
         end
         sda_pull = sel;
         idx++;
         bits = 9;
      end
endmodule // lcd_slave_model
`default_nettype wire

// *** tb/char_lcd_i2c_host_port_tb.sv ***
// Register-level testbench for the LCD I2C host port
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) \
   begin \
      samples_checked++; \
      if ((a) !== (e)) \
      begin \
         err_count++; \
         $display("BAD %0t got %h want %h", $time, (a), (e)); \
      end \
   end
module char_lcd_i2c_host_port_tb;
   logic        clk;
   logic        nrst = 1'b0;
   logic        wr = 1'b0;
   logic        rd = 1'b0;
   logic [7:0]  addr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic [31:0] rdata;
   logic [31:0] v;
   logic        sda_out;
   logic        sda_oe;
   logic        scl_out;
   logic        scl_oe;
   logic        lcd_rst_n;
   logic        pull_lo;
   logic        pull_hi;
   wire logic   sda_w;
   wire logic   scl_w;
   int          err_count = 0;
   int          samples_checked = 0;
   int          n;
   logic [7:0]  init5[8] = '{8'h38, 8'h39, 8'h14, 8'h79, 8'h50, 8'h6C, 8'h0C, 8'h01};
   logic [7:0]  init3[6] = '{8'h38, 8'h39, 8'h14, 8'h74, 8'h54, 8'h6F};

   // Pull-ups on both lines; every party may only pull low
   assign sda_w = (sda_oe ? sda_out : 1'b1) & !(pull_lo | pull_hi);
   assign scl_w = scl_oe ? scl_out : 1'b1;

   initial
   begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   char_lcd_i2c_host_port #(.CMD_WAIT(20), .QTR(16)) char_lcd_i2c_host_port_inst (
      .clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata(rdata), .sda_in(sda_w), .sda_out(sda_out), .sda_oe(sda_oe),
      .scl_out(scl_out), .scl_oe(scl_oe), .lcd_rst_n(lcd_rst_n));
   lcd_slave_model #(.ADDR(7'h3C)) slave_lo (
      .scl(scl_w), .sda(sda_w), .rst_n(lcd_rst_n), .sda_pull(pull_lo));
   lcd_slave_model #(.ADDR(7'h3F)) slave_hi (
      .scl(scl_w), .sda(sda_w), .rst_n(lcd_rst_n), .sda_pull(pull_hi));

   task automatic test_done;
      $display("checks %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe
   task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1 d = rdata;
   endtask

   // Poll one status bit; a frame lasts close to two thousand cycles, hence the wide bound
   task automatic wait_stat(input int b, input logic val);
      n = 0;
      do
      begin
         rd_reg(char_lcd_pkg::REG_STATUS, v);
         n++;
      end
      while (v[b] !== val && n < 30000);
      if (v[b] !== val)
      begin
         err_count++;
         $display("BAD %0t status wait ran out", $time);
         test_done();
      end
   endtask

   initial
   begin
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      #1 `CHK(lcd_rst_n, 1'b1)
      `CHK(sda_oe | scl_oe, 1'b0)
      `CHK(sda_out | scl_out, 1'b0)
      rd_reg(char_lcd_pkg::REG_STATUS, v);
      `CHK(v, 32'h0)
      rd_reg(8'h10, v);
      `CHK(v, 32'h0)
      wr_reg(char_lcd_pkg::REG_CTRL, 32'h8);
      repeat (2) @(posedge clk);
      #1 `CHK(lcd_rst_n, 1'b0)
      wr_reg(char_lcd_pkg::REG_CTRL, 32'h0);
      $display("reset test done");

      // Data word to the top address of the range
      wr_reg(char_lcd_pkg::REG_SLAVE, 32'h3);
      wr_reg(char_lcd_pkg::REG_WORD, 32'h141);
      wr_reg(char_lcd_pkg::REG_CTRL, 32'h4);
      rd_reg(char_lcd_pkg::REG_STATUS, v);
      `CHK(v[0], 1'b1)
      wait_stat(0, 1'b0);
      `CHK(v[1], 1'b0)
      `CHK(slave_hi.words.size(), 1)
      `CHK(slave_hi.words[0], 9'h141)
      `CHK(slave_lo.words.size(), 0)
      $display("send test done");

      // Nobody answers 0x3D: sticky refusal, then cleared
      wr_reg(char_lcd_pkg::REG_SLAVE, 32'h1);
      wr_reg(char_lcd_pkg::REG_CTRL, 32'h4);
      wait_stat(0, 1'b0);
      `CHK(v[1], 1'b1)
      wr_reg(char_lcd_pkg::REG_STATUS, 32'h2);
      rd_reg(char_lcd_pkg::REG_STATUS, v);
      `CHK(v[1], 1'b0)
      $display("refusal test done");

      // Full power-up sequence, 5 V table
      wr_reg(char_lcd_pkg::REG_SLAVE, 32'h0);
      wr_reg(char_lcd_pkg::REG_CTRL, 32'h3);
      wait_stat(2, 1'b1);
      `CHK(v[6:4], 3'h7)
      `CHK(slave_lo.words.size(), 8)
      for (int i = 0; i < 8; i++)
         `CHK(slave_lo.words[i], {1'b0, init5[i]})
      wait_stat(0, 1'b0);
      $display("5 V init test done");

      // 3 V table, cut short by a reset once the follower byte is received
      wr_reg(char_lcd_pkg::REG_CTRL, 32'h1);
      n = 0;
      while (slave_lo.words.size() < 14 && n < 60000)
      begin
         @(posedge clk);
         n++;
      end
      if (slave_lo.words.size() < 14)
      begin
         err_count++;
         $display("BAD %0t power-up wait ran out", $time);
         test_done();
      end
      for (int i = 0; i < 6; i++)
         `CHK(slave_lo.words[8 + i], {1'b0, init3[i]})
      nrst <= 1'b0;
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      #1 `CHK(sda_oe | scl_oe, 1'b0)
      `CHK(sda_w & scl_w, 1'b1)
      rd_reg(char_lcd_pkg::REG_STATUS, v);
      `CHK(v, 32'h0)
      $display("3 V init test done");
      test_done();
   end
endmodule // char_lcd_i2c_host_port_tb
`default_nettype wire
